// *** verilog/usbp_shadow_port.sv ***
`timescale 1ns/1ps
module usbp_shadow_port
    import usbp_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // Register port
    input wire usbp_bus_t BUS,
    output logic [31:0] RDATA,
    // Received characters
    input wire usbp_char_t RX_UART,
    input wire usbp_char_t RX_IR,
    // Characters to send
    output usbp_char_t TX_UART,
    input wire logic TX_UART_READY,
    output usbp_char_t TX_IR,
    input wire logic TX_IR_READY,
    // Mode and interrupt
    output logic IR_MODE,
    output logic IRQ
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] rx_mem_r [FIFO_DEPTH];
    logic [PTR_W-1:0] rx_rd_r;
    logic [PTR_W-1:0] rx_wr_r;
    logic [CNT_W-1:0] rx_cnt_r;
    logic [CNT_W-1:0] rx_cnt_nxt;
    logic [7:0] tx_mem_r [FIFO_DEPTH];
    logic [PTR_W-1:0] tx_rd_r;
    logic [PTR_W-1:0] tx_wr_r;
    logic [CNT_W-1:0] tx_cnt_r;
    logic [CNT_W-1:0] tx_cnt_nxt;
    logic fifo_en_r;
    logic ir_mode_r;
    logic lsr_ovr_r;
    logic [INT_W-1:0] int_stat_r;
    logic [INT_W-1:0] int_stat_nxt;
    logic [INT_W-1:0] int_mask_r;
    logic irq_r;
    logic [31:0] rdata_r;
    usbp_char_t tx_uart_r;
    usbp_char_t tx_ir_r;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic is_shadow(input logic [31:0] addr);
        logic [31:0] off;
        off = addr - SHADOW_ALIAS_0;
        return (off < SHADOW_SPAN) && (off[1:0] == 2'h0);
    endfunction

    logic sh_rd;
    logic sh_wr;
    logic ctrl_wr;
    logic lsr_rd;
    logic stat_wr;
    logic mask_wr;
    logic [31:0] rd_val;
    logic [7:0] rx_head;
    logic [7:0] tx_head;
    logic tx_holding_empty_flag;
    logic dr;

    assign rx_head = rx_mem_r[rx_rd_r];
    assign tx_head = tx_mem_r[tx_rd_r];
    assign tx_holding_empty_flag = (tx_cnt_r == CNT_ZERO);
    assign dr = (rx_cnt_r != CNT_ZERO);

    always_comb
    begin
        sh_rd = 1'b0;
        sh_wr = 1'b0;
        ctrl_wr = 1'b0;
        lsr_rd = 1'b0;
        stat_wr = 1'b0;
        mask_wr = 1'b0;
        rd_val = 32'h0000_0000;
        if (is_shadow(BUS.addr))
        begin
            sh_rd = BUS.rd;
            sh_wr = BUS.wr;
            rd_val = {24'h00_0000, rx_head};
        end
        else if (BUS.addr == CTRL_ADDR)
        begin
            ctrl_wr = BUS.wr;
            rd_val[CTRL_FIFO_EN_BIT] = fifo_en_r;
            rd_val[CTRL_IR_MODE_BIT] = ir_mode_r;
        end
        else if (BUS.addr == LINE_STAT_ADDR)
        begin
            lsr_rd = BUS.rd;
            rd_val[LSR_DR_BIT] = dr;
            rd_val[LSR_OVR_BIT] = lsr_ovr_r;
            rd_val[LSR_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag;
            rd_val[LSR_RX_LVL_LSB +: CNT_W] = rx_cnt_r;
            rd_val[LSR_TX_LVL_LSB +: CNT_W] = tx_cnt_r;
        end
        else if (BUS.addr == INT_STAT_ADDR)
        begin
            stat_wr = BUS.wr;
            rd_val[INT_W-1:0] = int_stat_r;
        end
        else if (BUS.addr == INT_MASK_ADDR)
        begin
            mask_wr = BUS.wr;
            rd_val[INT_W-1:0] = int_mask_r;
        end
    end

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    usbp_char_t rx_in;
    logic fifo_flush;
    logic rx_pop;
    logic rx_full;
    logic rx_push;
    logic rx_ovwr;
    logic rx_drop;

    // Changing the FIFO mode empties both buffers
    assign fifo_flush = ctrl_wr && (BUS.wdata[CTRL_FIFO_EN_BIT] != fifo_en_r);
    assign rx_in = ir_mode_r ? RX_IR : RX_UART;
    assign rx_pop = sh_rd && dr;
    assign rx_full = fifo_en_r ? (rx_cnt_r == FIFO_FULL_CNT) : dr;
    assign rx_push = rx_in.valid && (!rx_full || rx_pop);
    assign rx_ovwr = rx_in.valid && rx_full && !rx_pop && !fifo_en_r;
    assign rx_drop = rx_in.valid && rx_full && !rx_pop && fifo_en_r;

    always_comb
    begin
        rx_cnt_nxt = rx_cnt_r;
        if (fifo_flush)
            rx_cnt_nxt = CNT_ZERO;
        else if (rx_push && !rx_pop)
            rx_cnt_nxt = rx_cnt_r + CNT_ONE;
        else if (rx_pop && !rx_push)
            rx_cnt_nxt = rx_cnt_r - CNT_ONE;
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            rx_rd_r <= '0;
            rx_wr_r <= '0;
            rx_cnt_r <= CNT_ZERO;
        end
        else
        begin
            rx_cnt_r <= rx_cnt_nxt;
            if (fifo_flush)
            begin
                rx_rd_r <= '0;
                rx_wr_r <= '0;
            end
            else
            begin
                if (rx_push)
                    rx_wr_r <= rx_wr_r + PTR_W'(1);
                if (rx_pop)
                    rx_rd_r <= rx_rd_r + PTR_W'(1);
            end
        end
    end

    // Buffer loads SHADOW_RST at reset; once written, an empty buffer reads the stale entry at the read pointer
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            for (int i = 0; i < FIFO_DEPTH; i++)
                rx_mem_r[i] <= SHADOW_RST[7:0];
        end
        else if (rx_push)
            rx_mem_r[rx_wr_r] <= rx_in.data;
        else if (rx_ovwr)
            rx_mem_r[rx_rd_r] <= rx_in.data;
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    logic tx_acc;
    logic tx_pop;
    logic tx_full;
    logic tx_push;
    logic tx_ovwr;

    assign tx_acc = (tx_uart_r.valid && TX_UART_READY) || (tx_ir_r.valid && TX_IR_READY);
    assign tx_pop = (!(tx_uart_r.valid || tx_ir_r.valid) || tx_acc) && !tx_holding_empty_flag && !fifo_flush;
    assign tx_full = fifo_en_r ? (tx_cnt_r == FIFO_FULL_CNT) : !tx_holding_empty_flag;
    // writes into a full FIFO lost
    assign tx_push = sh_wr && (!tx_full || tx_pop);
    assign tx_ovwr = sh_wr && tx_full && !tx_pop && !fifo_en_r;

    always_comb
    begin
        tx_cnt_nxt = tx_cnt_r;
        if (fifo_flush)
            tx_cnt_nxt = CNT_ZERO;
        else if (tx_push && !tx_pop)
            tx_cnt_nxt = tx_cnt_r + CNT_ONE;
        else if (tx_pop && !tx_push)
            tx_cnt_nxt = tx_cnt_r - CNT_ONE;
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            tx_rd_r <= '0;
            tx_wr_r <= '0;
            tx_cnt_r <= CNT_ZERO;
        end
        else
        begin
            tx_cnt_r <= tx_cnt_nxt;
            if (fifo_flush)
            begin
                tx_rd_r <= '0;
                tx_wr_r <= '0;
            end
            else
            begin
                if (tx_push)
                    tx_wr_r <= tx_wr_r + PTR_W'(1);
                if (tx_pop)
                    tx_rd_r <= tx_rd_r + PTR_W'(1);
            end
        end
    end

    // only the low byte is stored
    always_ff @(posedge CLOCK)
    begin
        if (tx_push && !fifo_flush)
            tx_mem_r[tx_wr_r] <= BUS.wdata[7:0];
        else if (tx_ovwr && !fifo_flush)
            tx_mem_r[tx_rd_r] <= BUS.wdata[7:0];
    end

    // character goes to the serializer of the mode
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            tx_uart_r <= '0;
            tx_ir_r <= '0;
        end
        else if (tx_pop)
        begin
            tx_uart_r <= '{valid: !ir_mode_r, data: tx_head};
            tx_ir_r <= '{valid: ir_mode_r, data: tx_head};
        end
        else if (tx_acc)
        begin
            tx_uart_r.valid <= 1'b0;
            tx_ir_r.valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            fifo_en_r <= CTRL_FIFO_EN_RST;
            ir_mode_r <= CTRL_IR_MODE_RST;
        end
        else if (ctrl_wr)
        begin
            fifo_en_r <= BUS.wdata[CTRL_FIFO_EN_BIT];
            ir_mode_r <= BUS.wdata[CTRL_IR_MODE_BIT];
        end
    end

    // Overrun sticks until line status is read; a new one wins
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            lsr_ovr_r <= 1'b0;
        else if (rx_ovwr || rx_drop)
            lsr_ovr_r <= 1'b1;
        else if (lsr_rd)
            lsr_ovr_r <= 1'b0;
    end

    always_comb
    begin
        int_stat_nxt = int_stat_r;
        if (stat_wr)
            int_stat_nxt = int_stat_r & ~BUS.wdata[INT_W-1:0];
        int_stat_nxt[INT_RX_BIT] = int_stat_nxt[INT_RX_BIT] | rx_push;
        int_stat_nxt[INT_OVR_BIT] = int_stat_nxt[INT_OVR_BIT] | rx_ovwr | rx_drop;
        int_stat_nxt[INT_TX_HOLDING_EMPTY_FLAG_BIT] = int_stat_nxt[INT_TX_HOLDING_EMPTY_FLAG_BIT]
            | (!tx_holding_empty_flag && tx_cnt_nxt == CNT_ZERO);
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            int_stat_r <= INT_STAT_RST;
            int_mask_r <= INT_MASK_RST;
            irq_r <= 1'b0;
        end
        else
        begin
            int_stat_r <= int_stat_nxt;
            if (mask_wr)
                int_mask_r <= BUS.wdata[INT_W-1:0];
            irq_r <= |(int_stat_nxt & (mask_wr ? BUS.wdata[INT_W-1:0] : int_mask_r));
        end
    end

    // Read data stand for exactly one cycle
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            rdata_r <= 32'h0000_0000;
        else if (BUS.rd)
            rdata_r <= rd_val;
        else
            rdata_r <= 32'h0000_0000;
    end

    assign RDATA = rdata_r;
    assign TX_UART = tx_uart_r;
    assign TX_IR = tx_ir_r;
    assign IR_MODE = ir_mode_r;
    assign IRQ = irq_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_shadow_upper_zero: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        sh_rd |=> RDATA[31:8] == 24'h00_0000)
        else $error("shadow read upper bits not zero");

    a_alias_same_head: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (sh_rd && !fifo_flush) |=> RDATA[7:0] == $past(rx_head))
        else $error("alias read did not return buffer head");

    a_rx_fifo_pop: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (fifo_en_r && sh_rd && dr && !rx_in.valid && !fifo_flush)
        |=> rx_cnt_r == $past(rx_cnt_r) - CNT_ONE)
        else $error("fifo read did not pop");

    a_rx_overwrite: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (!fifo_en_r && dr && rx_in.valid && !sh_rd && !fifo_flush)
        |=> rx_cnt_r == CNT_ONE && rx_head == $past(rx_in.data) && int_stat_r[INT_OVR_BIT])
        else $error("single buffer overwrite wrong");

    a_rx_full_drop: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (fifo_en_r && rx_cnt_r == FIFO_FULL_CNT && rx_in.valid && !sh_rd && !fifo_flush)
        |=> $stable(rx_wr_r) && rx_cnt_r == FIFO_FULL_CNT && lsr_ovr_r)
        else $error("full receive fifo not preserved");

    a_rx_source: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (ir_mode_r && RX_IR.valid && !dr && !fifo_flush)
        |=> rx_head == $past(RX_IR.data))
        else $error("infrared character not stored");

    a_dr_report: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        lsr_rd |=> RDATA[LSR_DR_BIT] == ($past(rx_cnt_r) != CNT_ZERO))
        else $error("data ready flag wrong");

    a_tx_holding_empty_flag_clear: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (!fifo_en_r && tx_holding_empty_flag && sh_wr && !fifo_flush) |=> !tx_holding_empty_flag)
        else $error("holding empty not cleared");

    a_tx_replace: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (!fifo_en_r && !tx_holding_empty_flag && sh_wr && !tx_pop && !fifo_flush)
        |=> tx_head == $past(BUS.wdata[7:0]) && tx_cnt_r == CNT_ONE)
        else $error("pending character not replaced");

    a_tx_accept: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (fifo_en_r && tx_cnt_r < FIFO_FULL_CNT && sh_wr && !tx_pop && !fifo_flush)
        |=> tx_cnt_r == $past(tx_cnt_r) + CNT_ONE)
        else $error("fifo write not accepted");

    a_tx_full_lost: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (fifo_en_r && tx_cnt_r == FIFO_FULL_CNT && sh_wr && !tx_pop && !fifo_flush)
        |=> tx_cnt_r == FIFO_FULL_CNT && $stable(tx_wr_r) && $stable(tx_rd_r))
        else $error("write into full fifo not lost");

    a_tx_route: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        tx_pop |=> (TX_IR.valid == $past(ir_mode_r)) && (TX_UART.valid != $past(ir_mode_r))
            && TX_UART.data == $past(tx_head))
        else $error("character routed to wrong output");

endmodule // usbp_shadow_port

// *** verilog/usbp_pkg.sv ***
package usbp_pkg;

    // ------------------------------------------------------------
    // Buffer geometry
    // ------------------------------------------------------------
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned PTR_W = 4;
    localparam int unsigned CNT_W = 5;
    localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 5'h10;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

    // ------------------------------------------------------------
    // Shadow buffer aliases, one word each
    // ------------------------------------------------------------
    localparam logic [31:0] SHADOW_ALIAS_0 = 32'h5000_1030;
    localparam logic [31:0] SHADOW_ALIAS_7 = 32'h5000_104C;
    localparam logic [31:0] SHADOW_ALIAS_8 = 32'h5000_1050;
    localparam logic [31:0] SHADOW_SPAN = 32'h0000_0040;
    localparam logic [15:0] SHADOW_RST = 16'h0000;

    // ------------------------------------------------------------
    // Control, line status and interrupt registers
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_ADDR = 32'h5000_1000;
    localparam logic [31:0] LINE_STAT_ADDR = 32'h5000_1004;
    localparam logic [31:0] INT_STAT_ADDR = 32'h5000_1008;
    localparam logic [31:0] INT_MASK_ADDR = 32'h5000_100C;

    localparam int unsigned CTRL_FIFO_EN_BIT = 0;
    localparam int unsigned CTRL_IR_MODE_BIT = 1;
    localparam logic CTRL_FIFO_EN_RST = 1'h0;
    localparam logic CTRL_IR_MODE_RST = 1'h0;

    localparam int unsigned LSR_DR_BIT = 0;
    localparam int unsigned LSR_OVR_BIT = 1;
    localparam int unsigned LSR_TX_HOLDING_EMPTY_FLAG_BIT = 5;
    localparam int unsigned LSR_RX_LVL_LSB = 8;
    localparam int unsigned LSR_TX_LVL_LSB = 16;

    localparam int unsigned INT_W = 3;
    localparam int unsigned INT_RX_BIT = 0;
    localparam int unsigned INT_OVR_BIT = 1;
    localparam int unsigned INT_TX_HOLDING_EMPTY_FLAG_BIT = 2;
    localparam logic [INT_W-1:0] INT_STAT_RST = 3'h0;
    localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } usbp_char_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } usbp_bus_t;

endpackage

// *** verification/usbp_peer_model.sv ***
`timescale 1ns/1ps
module usbp_peer_model
    import usbp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Bench control
    input wire logic send,
    input wire logic [7:0] send_data,
    input wire logic send_ir,
    input wire logic stall,
    // Line side of the block
    output usbp_char_t rx_uart,
    output usbp_char_t rx_ir,
    input wire usbp_char_t tx_uart,
    output logic tx_uart_ready,
    input wire usbp_char_t tx_ir,
    output logic tx_ir_ready,
    // Characters taken from the block
    output logic [7:0] got_data,
    output logic got_ir,
    output logic [7:0] got_cnt
);
    // ------------------------------------------------------------
    // Characters towards the block
    // ------------------------------------------------------------
    // serial or infrared input
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_uart <= '0;
            rx_ir <= '0;
        end
        else
        begin
            rx_uart.valid <= send && !send_ir;
            rx_ir.valid <= send && send_ir;
            // Idle data keeps changing so stale bytes never match
            rx_uart.data <= send ? send_data : ~rx_uart.data;
            rx_ir.data <= send ? send_data : ~rx_ir.data;
        end
    end

    // ------------------------------------------------------------
    // Characters from the block
    // ------------------------------------------------------------
    assign tx_uart_ready = !stall;
    assign tx_ir_ready = !stall;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            got_data <= 8'h00;
            got_ir <= 1'b0;
            got_cnt <= 8'h00;
        end
        else if (tx_uart.valid && tx_uart_ready)
        begin
            got_data <= tx_uart.data;
            got_ir <= 1'b0;
            got_cnt <= got_cnt + 8'h01;
        end
        else if (tx_ir.valid && tx_ir_ready)
        begin
            got_data <= tx_ir.data;
            got_ir <= 1'b1;
            got_cnt <= got_cnt + 8'h01;
        end
    end
endmodule // usbp_peer_model

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
    import usbp_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    usbp_bus_t bus = '0;
    logic [31:0] rdata;
    usbp_char_t rx_uart, rx_ir, tx_uart, tx_ir;
    logic tx_uart_ready, tx_ir_ready, ir_mode, irq, got_ir;
    logic send = 1'b0;
    logic [7:0] send_data = 8'h00;
    logic send_ir = 1'b0;
    logic stall = 1'b0;
    logic [7:0] got_data, got_cnt;
    logic [31:0] rd_val;
    int n_mismatch = 0;
    int tests_run = 0;

    always #5 clock = ~clock;

    usbp_shadow_port i_dut (.CLOCK(clock), .NRST(nrst), .BUS(bus), .RDATA(rdata),
        .RX_UART(rx_uart), .RX_IR(rx_ir), .TX_UART(tx_uart), .TX_UART_READY(tx_uart_ready),
        .TX_IR(tx_ir), .TX_IR_READY(tx_ir_ready), .IR_MODE(ir_mode), .IRQ(irq));

    usbp_peer_model i_peer (.clock(clock), .nrst(nrst), .send(send), .send_data(send_data),
        .send_ir(send_ir), .stall(stall), .rx_uart(rx_uart), .rx_ir(rx_ir),
        .tx_uart(tx_uart), .tx_uart_ready(tx_uart_ready), .tx_ir(tx_ir),
        .tx_ir_ready(tx_ir_ready), .got_data(got_data), .got_ir(got_ir), .got_cnt(got_cnt));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
        @(posedge clock);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        rd_val = rdata;
        chk(name, exp, rd_val);
    endtask

    task automatic put(input logic [7:0] d, input logic ir);
        @(posedge clock);
        send <= 1'b1;
        send_data <= d;
        send_ir <= ir;
        @(posedge clock);
        send <= 1'b0;
        cyc(2);
    endtask

    task automatic set_stall(input logic s);
        @(posedge clock);
        stall <= s;
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("outputs", 32'h0000_0000, {12'h000, tx_uart, tx_ir, ir_mode, irq});
        rd_chk("line status", LINE_STAT_ADDR, 32'h0000_0020);
        rd_chk("alias 7", SHADOW_ALIAS_7, {16'h0000, SHADOW_RST});
        rd_chk("control", CTRL_ADDR, 32'h0000_0000);
        wr(SHADOW_ALIAS_0 + SHADOW_SPAN, 32'hFFFF_FFFF);
        rd_chk("unmapped", SHADOW_ALIAS_0 + SHADOW_SPAN, 32'h0000_0000);
        rd_chk("line status", LINE_STAT_ADDR, 32'h0000_0020);
    endtask

    task automatic t_rx_plain;
        put(8'hA5, 1'b0);
        rd_chk("line status", LINE_STAT_ADDR, 32'h0000_0121);
        put(8'h3C, 1'b0);
        rd_chk("int status", INT_STAT_ADDR, 32'h0000_0003);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        wr(INT_MASK_ADDR, 32'h0000_0003);
        cyc(2);
        chk("irq on", 32'h0000_0001, {31'h0, irq});
        wr(INT_STAT_ADDR, 32'h0000_0003);
        cyc(2);
        chk("irq off", 32'h0000_0000, {31'h0, irq});
        rd_chk("line status", LINE_STAT_ADDR, 32'h0000_0123);
        rd_chk("alias 7", SHADOW_ALIAS_7, 32'h0000_003C);
        rd_chk("line status", LINE_STAT_ADDR, 32'h0000_0020);
        wr(CTRL_ADDR, 32'h0000_0002);
        cyc(1);
        chk("ir mode", 32'h0000_0001, {31'h0, ir_mode});
        put(8'h77, 1'b0);
        put(8'h5A, 1'b1);
        rd_chk("alias 8", SHADOW_ALIAS_8, 32'h0000_005A);
        rd_chk("line status", LINE_STAT_ADDR, 32'h0000_0020);
        wr(INT_STAT_ADDR, 32'h0000_0007);
    endtask

    task automatic t_rx_fifo;
        wr(CTRL_ADDR, 32'h0000_0001);
        for (int i = 0; i < 16; i++)
            put(8'h10 + 8'(i), 1'b0);
        put(8'hEE, 1'b0);
        rd_chk("line status", LINE_STAT_ADDR, 32'h0000_1023);
        for (int i = 0; i < 16; i++)
            rd_chk("fifo head", SHADOW_ALIAS_0 + 32'(4 * i), {24'h0, 8'h10 + 8'(i)});
        rd_chk("line status", LINE_STAT_ADDR, 32'h0000_0020);
    endtask

    task automatic t_tx_plain;
        wr(CTRL_ADDR, 32'h0000_0000);
        set_stall(1'b1);
        rd_chk("line status", LINE_STAT_ADDR, 32'h0000_0020);
        wr(SHADOW_ALIAS_7, 32'hFFFF_FF11);
        cyc(3);
        chk("uart out", 32'h0000_0111, {23'h0, tx_uart});
        rd_chk("line status", LINE_STAT_ADDR, 32'h0000_0020);
        rd_chk("int status", INT_STAT_ADDR, 32'h0000_0007);
        wr(INT_STAT_ADDR, 32'h0000_0007);
        wr(SHADOW_ALIAS_8, 32'h0000_0022);
        rd_chk("line status", LINE_STAT_ADDR, 32'h0001_0000);
        wr(SHADOW_ALIAS_8, 32'h0000_0033);
        rd_chk("line status", LINE_STAT_ADDR, 32'h0001_0000);
        set_stall(1'b0);
        cyc(8);
        chk("sent", 32'h0000_0233, {16'h0, got_cnt, got_data});
        wr(CTRL_ADDR, 32'h0000_0002);
        wr(SHADOW_ALIAS_7, 32'h0000_0044);
        cyc(6);
        chk("ir sent", 32'h0003_0144, {8'h0, got_cnt, 7'h0, got_ir, got_data});
    endtask

    task automatic t_tx_fifo;
        wr(CTRL_ADDR, 32'h0000_0001);
        set_stall(1'b1);
        for (int i = 0; i < 18; i++)
            wr(SHADOW_ALIAS_0 + 32'(4 * (i % 16)), {24'h0, 8'h40 + 8'(i)});
        rd_chk("line status", LINE_STAT_ADDR, 32'h0010_0000);
        set_stall(1'b0);
        cyc(60);
        chk("sent", 32'h0000_1450, {16'h0, got_cnt, got_data});
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        cyc(10);
        nrst <= 1'b1;
        t_reset();
        t_rx_plain();
        t_rx_fifo();
        t_tx_plain();
        t_tx_fifo();
        stop_test();
    end

    initial
    begin
        #50us;
        n_mismatch++;
        stop_test();
    end
endmodule // tb
